// ---- design/ioxs_pkg.sv ----
// Package of constants and types for the I2C slave address decode and soft reset block
package ioxs_pkg;

  // ****************************************************************
  // Address-select pin states
  // ****************************************************************
  typedef enum logic [1:0] {
    IOXS_PIN_GND = 2'h0,
    IOXS_PIN_VDD = 2'h1,
    IOXS_PIN_SCL = 2'h2,
    IOXS_PIN_SDA = 2'h3
  } ioxs_pin_t;

  // ****************************************************************
  // Reserved addresses, command value, port reset value and sizes
  // ****************************************************************
  localparam logic [6:0] IOXS_GCALL_ADDR = 7'h00;
  localparam logic [6:0] IOXS_DEVID_ADDR = 7'h7C;
  localparam logic [7:0] IOXS_SWRST_CMD = 8'h06;
  localparam logic [6:0] IOXS_ADDR_NONE = 7'h7F;
  localparam logic [15:0] IOXS_PORT_RESET = 16'hFFFF;
  localparam int IOXS_ADDR_TABLE_SIZE = 64;
  localparam logic [3:0] IOXS_BITS_PER_BYTE = 4'h8;

  // ****************************************************************
  // Byte-level states of the slave
  // ****************************************************************
  typedef enum logic [6:0] {
    IOXS_ST_IDLE = 7'b000_0001,
    IOXS_ST_ADDR = 7'b000_0010,
    IOXS_ST_ACK = 7'b000_0100,
    IOXS_ST_GCMD = 7'b000_1000,
    IOXS_ST_ARMED = 7'b001_0000,
    IOXS_ST_DATA = 7'b010_0000,
    IOXS_ST_IGNORE = 7'b100_0000
  } ioxs_state_t;

endpackage

// ---- design/ioxs_addr_map.sv ----
// Lookup of the own slave address from the three address-select pin states
`timescale 1ns/1ps
module ioxs_addr_map
  import ioxs_pkg::*;
(
  // Classified pin states
  input ioxs_pkg::ioxs_pin_t pin_hi,
  input ioxs_pkg::ioxs_pin_t pin_mid,
  input ioxs_pkg::ioxs_pin_t pin_lo,
  // Resulting 7-bit address
  output logic [6:0] own_addr
);

  // ****************************************************************
  // Table built from the pin pattern: {hi,mid,lo} is the index
  // ****************************************************************
  function automatic logic [6:0] lookup(input ioxs_pin_t h, input ioxs_pin_t m, input ioxs_pin_t l);
    logic h_bus;
    logic m_bus;
    logic l_bus;
    logic [6:0] a;
    h_bus = h[1];
    m_bus = m[1];
    l_bus = l[1];
    a = IOXS_ADDR_NONE;
    // Hi pin on a rail gives address bytes 20h..5Eh, on a bus line A0h..EEh
    if (!h_bus)
    begin
      if (m_bus)
        a = {3'h1, l_bus, h[0], m[0], l[0]};
      else
        a = {3'h2, l_bus, h[0], m[0], l[0]};
    end
    else
    begin
      if (m_bus)
        a = {3'h5, l_bus, h[0], m[0], l[0]};
      else if (l_bus)
        a = {3'h7, 1'b0, h[0], m[0], l[0]};
      else
        a = {3'h6, 1'b0, h[0], m[0], l[0]};
    end
    return a;
  endfunction

  // Combinational lookup keeps the address live with the pin states
  always_comb
  begin
    own_addr = lookup(pin_hi, pin_mid, pin_lo);
  end

endmodule

// ---- design/ioxs_slave.sv ----
// I2C slave front end: own-address match, general call soft reset, device ID address
//
// Overview of operation
// - Own address from 64-entry pin-state lookup
// - Also answer the device-identification address
// - Acknowledge general call only with write
// - Never acknowledge general call with read
// - Acknowledge command byte only if 06h
// - Other command byte: no ack, no arm
// - No ack for further bytes after command
// - STOP after acked 06h resets to defaults
// - Repeated START cancels pending soft reset
// - Last address bit gives direction, 1 read
// - Reset value drives all port lines high
// - Reserved addresses never match as own
`timescale 1ns/1ps
module ioxs_slave
  import ioxs_pkg::*;
(
  // Clock and reset
  input logic clk,
  input logic rstn,
  // I2C bus, sampled synchronously
  input logic scl_in,
  input logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Address-select pins
  input logic addr_select_pin_hi,
  input logic addr_select_pin_mid,
  input logic addr_select_pin_lo,
  // Status towards the rest of the device
  output logic own_selected,
  output logic own_read,
  output logic devid_selected,
  output logic soft_reset,
  output logic [15:0] port_state
);

  // ****************************************************************
  // State record
  // ****************************************************************
  typedef struct packed {
    logic scl_d;
    logic sda_d;
    ioxs_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic ack_drive;
    logic gcall;
    logic armed;
    logic own_sel;
    logic own_rd;
    logic dev_sel;
    logic srst;
    logic [2:0] seen_vdd;
    logic [2:0] diff_scl;
    logic [2:0] diff_sda;
    logic [15:0] port;
  } ioxs_reg_t;

  ioxs_reg_t r;
  ioxs_reg_t next_r;
  ioxs_pin_t pin_state [3];
  logic [2:0] sel_pins;
  logic [6:0] own_addr;
  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;
  logic [7:0] byte_in;

  assign sel_pins = {addr_select_pin_hi, addr_select_pin_mid, addr_select_pin_lo};

  // ****************************************************************
  // Pin classification
  // ****************************************************************
  // A pin that ever differs from SCL cannot be tied to SCL; it counts as a rail only once it has differed from both lines
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_cls
      always_comb
      begin
        if (r.diff_scl[gi] && r.diff_sda[gi])
          pin_state[gi] = r.seen_vdd[gi] ? IOXS_PIN_VDD : IOXS_PIN_GND;
        else if (!r.diff_scl[gi])
          pin_state[gi] = IOXS_PIN_SCL;
        else
          pin_state[gi] = IOXS_PIN_SDA;
      end
    end
  endgenerate

  ioxs_addr_map u_map (
    .pin_hi(pin_state[2]),
    .pin_mid(pin_state[1]),
    .pin_lo(pin_state[0]),
    .own_addr(own_addr)
  );

  // Bus condition detectors on the registered copies
  assign start_cond = r.scl_d && scl_in && r.sda_d && !sda_in;
  assign stop_cond = r.scl_d && scl_in && !r.sda_d && sda_in;
  assign scl_rise = !r.scl_d && scl_in;
  assign scl_fall = r.scl_d && !scl_in;
  assign byte_in = {r.shreg[6:0], sda_in};

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    next_r = r;
    next_r.scl_d = scl_in;
    next_r.sda_d = sda_in;
    next_r.srst = 1'b0;
    // Watch every pin against the live lines; a rail pin quickly differs from both
    for (int i = 0; i < 3; i++)
    begin
      if (sel_pins[i] != scl_in)
        next_r.diff_scl[i] = 1'b1;
      if (sel_pins[i] != sda_in)
        next_r.diff_sda[i] = 1'b1;
      next_r.seen_vdd[i] = sel_pins[i];
    end
    if (start_cond)
    begin
      // Repeated START drops any armed reset
      next_r.armed = 1'b0;
      next_r.st = IOXS_ST_ADDR;
      next_r.bitcnt = 4'h0;
      next_r.ack_drive = 1'b0;
      next_r.gcall = 1'b0;
      next_r.own_sel = 1'b0;
      // A stale read flag would otherwise decide the acks of a later transfer
      next_r.own_rd = 1'b0;
      next_r.dev_sel = 1'b0;
    end
    else if (stop_cond)
    begin
      if (r.armed)
      begin
        // Return to power-up values, addressable again from idle
        next_r.port = IOXS_PORT_RESET;
        next_r.srst = 1'b1;
      end
      next_r.armed = 1'b0;
      next_r.st = IOXS_ST_IDLE;
      next_r.ack_drive = 1'b0;
      next_r.own_sel = 1'b0;
      next_r.dev_sel = 1'b0;
      next_r.gcall = 1'b0;
    end
    else if (scl_fall && r.bitcnt == IOXS_BITS_PER_BYTE)
    begin
      // Ninth clock begins: decide whether to pull SDA low
      next_r.bitcnt = 4'h9;
      case (r.st)
        IOXS_ST_ADDR:
        begin
          if (r.shreg[7:1] == IOXS_GCALL_ADDR)
          begin
            next_r.ack_drive = !r.shreg[0];
            next_r.gcall = !r.shreg[0];
          end
          else if (r.shreg[7:1] == IOXS_DEVID_ADDR)
          begin
            next_r.ack_drive = 1'b1;
            next_r.dev_sel = 1'b1;
          end
          else if (r.shreg[7:1] == own_addr && own_addr != IOXS_ADDR_NONE && own_addr != IOXS_GCALL_ADDR)
          begin
            next_r.ack_drive = 1'b1;
            next_r.own_sel = 1'b1;
            next_r.own_rd = r.shreg[0];
          end
          else
            next_r.ack_drive = 1'b0;
        end
        IOXS_ST_GCMD:
        begin
          next_r.ack_drive = (r.shreg == IOXS_SWRST_CMD);
          next_r.armed = (r.shreg == IOXS_SWRST_CMD);
        end
        IOXS_ST_DATA:
          next_r.ack_drive = !r.own_rd;
        default:
        begin
          // An unacknowledged byte after the command aborts the pending reset
          next_r.ack_drive = 1'b0;
          next_r.armed = 1'b0;
        end
      endcase
    end
    else if (scl_fall && r.bitcnt == 4'h9)
    begin
      // End of acknowledge clock: choose how the next byte is handled
      next_r.ack_drive = 1'b0;
      next_r.bitcnt = 4'h0;
      if (!r.ack_drive)
        next_r.st = IOXS_ST_IGNORE;
      else if (r.st == IOXS_ST_ADDR && r.gcall)
        next_r.st = IOXS_ST_GCMD;
      else if (r.st == IOXS_ST_GCMD)
        next_r.st = IOXS_ST_IGNORE;
      else if (r.st == IOXS_ST_ADDR)
        next_r.st = IOXS_ST_DATA;
    end
    else if (scl_rise && r.bitcnt < IOXS_BITS_PER_BYTE && r.st != IOXS_ST_IDLE)
    begin
      next_r.shreg = byte_in;
      next_r.bitcnt = r.bitcnt + 4'h1;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      r <= '0;
      r.scl_d <= 1'b1;
      r.sda_d <= 1'b1;
      r.st <= IOXS_ST_IDLE;
      r.port <= IOXS_PORT_RESET;
    end
    else
      r <= next_r;
  end

  // Outputs; open-drain SDA only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n = !r.ack_drive;
  assign own_selected = r.own_sel;
  assign own_read = r.own_rd;
  assign devid_selected = r.dev_sel;
  assign soft_reset = r.srst;
  assign port_state = r.port;

endmodule

// ---- tb/ioxs_slave_asserts.sv ----
// Port-level concurrent checks for the I2C slave front end
`timescale 1ns/1ps
module ioxs_slave_asserts
(
  // Clock, reset and bus
  input logic clk,
  input logic rstn,
  input logic scl_in,
  input logic sda_in,
  input logic sda_out,
  input logic sda_oe_n,
  // Address-select pins
  input logic addr_select_pin_hi,
  input logic addr_select_pin_mid,
  input logic addr_select_pin_lo,
  // Status
  input logic own_selected,
  input logic own_read,
  input logic devid_selected,
  input logic soft_reset,
  input logic [15:0] port_state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ****************************************************************
  // Reset pulse, port value and select flags
  // ****************************************************************
  port_high_a: assert property (port_state == 16'hFFFF) else $error("port lines not all high");
  pulse_one_a: assert property (soft_reset |=> !soft_reset) else $error("soft reset wider than one cycle");
  reset_idle_a: assert property ($rose(soft_reset) |-> scl_in && sda_in) else $error("soft reset off idle bus");
  sel_clear_a: assert property (soft_reset |=> !own_selected && !devid_selected) else $error("select kept");
  sel_excl_a: assert property (!(own_selected && devid_selected)) else $error("two addresses selected");
  // ****************************************************************
  // Acknowledge timing: only moves while SCL is low, so the master never sees a glitch
  // ****************************************************************
  ack_launch_a: assert property ($fell(sda_oe_n) |-> !scl_in) else $error("ack launched with SCL high");
  ack_hold_a: assert property (!sda_oe_n && scl_in |=> !sda_oe_n) else $error("ack dropped with SCL high");
  ack_release_a: assert property ($rose(sda_oe_n) |-> !scl_in) else $error("ack released with SCL high");
  ack_span_a: assert property ($fell(sda_oe_n) |-> ##[1:200] sda_oe_n) else $error("ack never released");
endmodule
bind ioxs_slave ioxs_slave_asserts u_chk (.clk(clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_select_pin_hi(addr_select_pin_hi),
  .addr_select_pin_mid(addr_select_pin_mid), .addr_select_pin_lo(addr_select_pin_lo),
  .own_selected(own_selected), .own_read(own_read), .devid_selected(devid_selected),
  .soft_reset(soft_reset), .port_state(port_state));

// ---- tb/ioxs_i2c_master.sv ----
// Behavioural I2C bus master, one data bit takes 12 clk cycles
`timescale 1ns/1ps
module ioxs_i2c_master
(
  // Clock and wired data line
  input wire logic clk,
  input wire logic sda_w,
  // Bus drive, high means released to the pull-up
  output logic scl,
  output logic sda_m
);
  // Idle bus at time zero
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // Third of an SCL bit period
  task automatic q();
    repeat (4) @(posedge clk);
  endtask
  // START or repeated START: SDA falls while SCL is high
  task automatic start();
    sda_m <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_m <= 1'b0;
    q();
    scl <= 1'b0;
    q();
  endtask
  // Eight bits MSB first, then a ninth clock with SDA released
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--)
    begin
      sda_m <= (i == 0) ? 1'b1 : b[i-1];
      q();
      scl <= 1'b1;
      q();
      ack = ~sda_w;
      scl <= 1'b0;
      q();
    end
  endtask
  // STOP: SDA rises while SCL is high, then bus free time
  task automatic stop();
    sda_m <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_m <= 1'b1;
    q();
    q();
  endtask
endmodule

// ---- tb/i2c_slave_addr_decode_soft_reset_tb.sv ----
// Self-checking bench for the I2C slave address decode and soft reset block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module i2c_slave_addr_decode_soft_reset_tb;
  import ioxs_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic a, sda_out, sda_oe_n, own_selected, own_read, devid_selected, soft_reset;
  logic scl, sda_m;
  logic [15:0] port_state;
  ioxs_pin_t ph = IOXS_PIN_VDD, pm = IOXS_PIN_VDD, pl = IOXS_PIN_VDD;
  int miscompares = 0, checks_done = 0, cyc = 0, nsr = 0;
  wire sda_w = sda_m & (sda_oe_n | sda_out);
  // Level of a select pin tied to a rail or to a bus line
  function automatic logic lvl(ioxs_pin_t p, logic c, logic d);
    return (p == IOXS_PIN_SCL) ? c : (p == IOXS_PIN_SDA) ? d : (p == IOXS_PIN_VDD);
  endfunction
  ioxs_i2c_master m (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));
  ioxs_slave dut (.clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .addr_select_pin_hi(lvl(ph, scl, sda_w)), .addr_select_pin_mid(lvl(pm, scl, sda_w)),
    .addr_select_pin_lo(lvl(pl, scl, sda_w)), .own_selected(own_selected), .own_read(own_read),
    .devid_selected(devid_selected), .soft_reset(soft_reset), .port_state(port_state));
  // 200 MHz clock
  always #2.5 clk = ~clk;
  // Soft reset pulse count and hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (soft_reset === 1'b1)
      nsr++;
    if (cyc == 30000)
    begin
      miscompares++;
      summarize();
    end
  end
  task automatic fin(input string n);
    $display("test %s done", n);
  endtask
  // Own address per pin states, each after a fresh reset and warm-up traffic
  task automatic t_own();
    ioxs_pin_t cfg [4][3] = '{'{IOXS_PIN_SDA, IOXS_PIN_VDD, IOXS_PIN_SDA}, '{IOXS_PIN_VDD, IOXS_PIN_VDD,
      IOXS_PIN_VDD}, '{IOXS_PIN_GND, IOXS_PIN_SCL, IOXS_PIN_GND}, '{IOXS_PIN_SCL, IOXS_PIN_SDA, IOXS_PIN_SCL}};
    logic [6:0] ex [4] = '{7'h77, 7'h27, 7'h10, 7'h5A};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      ph <= cfg[i][0];
      pm <= cfg[i][1];
      pl <= cfg[i][2];
      rstn <= 1'b0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      m.start();
      m.wbyte(8'h12, a);
      `CHK("stranger_ack", 1'b0, a)
      m.stop();
      m.start();
      m.wbyte({ex[i], i[0]}, a);
      `CHK("own_ack", 1'b1, a)
      `CHK("own_sel", 1'b1, own_selected)
      `CHK("own_read", i[0], own_read)
      m.stop();
    end
    fin("own");
  endtask
  // General call write, command, STOP: one reset pulse
  task automatic t_gc_ok();
    int n;
    m.start();
    m.wbyte(8'h00, a);
    `CHK("gc_ack", 1'b1, a)
    m.wbyte(IOXS_SWRST_CMD, a);
    `CHK("cmd_ack", 1'b1, a)
    n = nsr;
    m.stop();
    `CHK("sr_pulse", n + 1, nsr)
    `CHK("port", 16'hFFFF, port_state)
    `CHK("gc_not_own", 1'b0, own_selected)
    fin("gc_ok");
  endtask
  // General call with read direction is refused
  task automatic t_gc_rd();
    m.start();
    m.wbyte(8'h01, a);
    `CHK("gc_rd_ack", 1'b0, a)
    m.stop();
    fin("gc_rd");
  endtask
  // Wrong command byte: no ack, no reset
  task automatic t_gc_bad();
    int n;
    m.start();
    m.wbyte(8'h00, a);
    m.wbyte(8'h05, a);
    `CHK("bad_ack", 1'b0, a)
    n = nsr;
    m.stop();
    `CHK("bad_sr", n, nsr)
    fin("gc_bad");
  endtask
  // Byte after the command is refused
  task automatic t_gc_more();
    int n;
    m.start();
    m.wbyte(8'h00, a);
    m.wbyte(IOXS_SWRST_CMD, a);
    m.wbyte(IOXS_SWRST_CMD, a);
    `CHK("more_ack", 1'b0, a)
    n = nsr;
    m.stop();
    `CHK("more_sr", n, nsr)
    fin("gc_more");
  endtask
  // Repeated START cancels the reset and the own address still answers
  task automatic t_gc_rs();
    int n;
    m.start();
    m.wbyte(8'h00, a);
    m.wbyte(IOXS_SWRST_CMD, a);
    n = nsr;
    m.start();
    m.wbyte({7'h5A, 1'b0}, a);
    `CHK("rs_own_ack", 1'b1, a)
    m.stop();
    `CHK("rs_sr", n, nsr)
    fin("gc_rs");
  endtask
  // Device identification address is acknowledged
  task automatic t_devid();
    m.start();
    m.wbyte({IOXS_DEVID_ADDR, 1'b0}, a);
    `CHK("id_ack", 1'b1, a)
    `CHK("id_sel", 1'b1, devid_selected)
    m.stop();
    fin("devid");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    t_own();
    t_gc_ok();
    t_gc_rd();
    t_gc_bad();
    t_gc_more();
    t_gc_rs();
    t_devid();
    summarize();
  end
endmodule
